// file: design/alcr_core.sv
// Execute logic that loads the accumulator from control registers or the stack pointer.
`timescale 1ns/10ps
module alcr_core import alcr_pkg::*; #(
  parameter logic [9:0] ADC_C_OPCODE = ALCR_OP_LOAD_ADC_CTRL_C
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Instruction fetched this machine cycle.
  input wire logic instr_valid_i,
  input wire logic [9:0] opcode_i,
  // Source registers.
  input wire logic [3:0] adc_ctrl_b_i,
  input wire logic [3:0] adc_ctrl_c_i,
  input wire logic [2:0] stack_pointer_i,
  input wire logic [3:0] irq_ctrl_a_i,
  input wire logic [3:0] irq_ctrl_b_i,
  input wire logic [3:0] timer_ctrl_a_i,
  input wire logic [3:0] timer_ctrl_b_i,
  input wire logic [3:0] timer_ctrl_c_i,
  // Read enables toward the source registers.
  output logic [ALCR_NOPS-1:0] rd_en_o,
  output logic hit_o,
  // Accumulator write path.
  output logic acc_we_o,
  output logic [3:0] acc_data_o,
  // Sequencer side effects.
  output logic carry_we_o,
  output logic skip_o
);

  typedef struct packed {
    logic [3:0] acc;
    logic we;
  } alcr_state_t;

  alcr_state_t state_q;
  alcr_state_t state_d;
  logic [ALCR_NOPS-1:0] sel;
  logic [ALCR_NOPS-1:0][3:0] src;

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Decode the opcode table.
  alcr_decode #(
    .ADC_C_OPCODE(ADC_C_OPCODE)
  ) u_decode (
    .valid_i(instr_valid_i),
    .opcode_i(opcode_i),
    .sel_o(sel)
  );

  // ****************************************************************
  // Source gathering
  // ****************************************************************
  assign src[ALCR_IDX_ADC_B] = adc_ctrl_b_i;
  assign src[ALCR_IDX_ADC_C] = adc_ctrl_c_i;
  assign src[ALCR_IDX_SP] = {1'b0, stack_pointer_i};
  assign src[ALCR_IDX_IRQ_A] = irq_ctrl_a_i;
  assign src[ALCR_IDX_IRQ_B] = irq_ctrl_b_i;
  assign src[ALCR_IDX_TMR_A] = timer_ctrl_a_i;
  assign src[ALCR_IDX_TMR_B] = timer_ctrl_b_i;
  assign src[ALCR_IDX_TMR_C] = timer_ctrl_c_i;

  // Read enables are observation only.
  // Enables stay combinational so a source can present its value in the decode cycle.
  assign rd_en_o = sel;
  assign hit_o = |sel;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    state_d.we = 1'b0;
    if (|sel) begin
      state_d.acc = 4'h0;
      for (int i = 0; i < ALCR_NOPS; i++) begin
        if (sel[i]) begin
          state_d.acc = state_d.acc | src[i];
        end
      end
      state_d.we = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= '{acc: ALCR_ACC_RST, we: 1'b0};
    end else begin
      state_q <= state_d;
    end
  end

  assign acc_we_o = state_q.we;
  assign acc_data_o = state_q.acc;
  assign carry_we_o = 1'b0;
  assign skip_o = 1'b0;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_issue(logic [9:0] code);
    instr_valid_i && (opcode_i == code);
  endsequence

  sequence s_write(logic [3:0] val);
    acc_we_o && (acc_data_o == val);
  endsequence

  sequence s_any_hit;
    hit_o;
  endsequence

  sequence s_idle;
    !hit_o;
  endsequence

  sequence s_strobe;
    acc_we_o;
  endsequence

  property p_load(logic [9:0] code, logic [3:0] val);
    s_issue(code) |=> s_write($past(val));
  endproperty

  property p_no_write_after_idle;
    s_idle |=> !acc_we_o;
  endproperty

  property p_write_needs_hit;
    s_strobe |-> $past(hit_o);
  endproperty

  // Between loads the accumulator value stands.
  property p_hold_after_idle;
    s_idle |=> $stable(acc_data_o);
  endproperty

  // Loads in consecutive cycles each give their own one-cycle strobe.
  property p_back_to_back;
    s_any_hit ##1 s_any_hit |-> s_strobe ##1 s_strobe;
  endproperty

  // ****************************************************************
  // Per-instruction loads
  // ****************************************************************
  load_adc_b_a: assert property (p_load(ALCR_OP_LOAD_ADC_CTRL_B, adc_ctrl_b_i))
    else $error("adc ctrl b load wrong");
  load_adc_c_a: assert property (p_load(ADC_C_OPCODE, adc_ctrl_c_i))
    else $error("adc ctrl c load wrong");
  load_sp_a: assert property (s_issue(ALCR_OP_LOAD_STACK_POINTER) |=>
    acc_we_o && !acc_data_o[3] && (acc_data_o[2:0] == $past(stack_pointer_i)))
    else $error("stack pointer load wrong");
  load_irq_a_a: assert property (p_load(ALCR_OP_LOAD_IRQ_CTRL_A, irq_ctrl_a_i))
    else $error("irq ctrl a load wrong");
  load_irq_b_a: assert property (p_load(10'h055, irq_ctrl_b_i))
    else $error("irq ctrl b load wrong");
  load_tmr_a_a: assert property (p_load(ALCR_OP_LOAD_TIMER_CTRL_A, timer_ctrl_a_i))
    else $error("timer ctrl a load wrong");
  load_tmr_b_a: assert property (p_load(10'h24c, timer_ctrl_b_i))
    else $error("timer ctrl b load wrong");
  load_tmr_c_a: assert property (p_load(10'h24d, timer_ctrl_c_i))
    else $error("timer ctrl c load wrong");

  // ****************************************************************
  // Timing and side effects
  // ****************************************************************
  single_cycle_a: assert property (p_no_write_after_idle)
    else $error("accumulator write without decode");
  strobe_source_a: assert property (p_write_needs_hit)
    else $error("accumulator write strobe without a decoded load");
  acc_hold_a: assert property (p_hold_after_idle)
    else $error("accumulator value changed without a load");
  back_to_back_a: assert property (p_back_to_back)
    else $error("back to back loads did not give one strobe each");
  no_side_effect_a: assert property (hit_o |-> !carry_we_o && !skip_o && $onehot(rd_en_o))
    else $error("side effect during load");
  idle_quiet_a: assert property (!instr_valid_i |-> !hit_o && (rd_en_o == '0))
    else $error("read enable without a valid instruction");
  enable_onehot_a: assert property ($onehot0(rd_en_o))
    else $error("more than one source enabled");

  // ****************************************************************
  // Per-slot source routing
  // ****************************************************************
  // Each enable routes only its own source.
  for (genvar g = 0; g < ALCR_NOPS; g++) begin : g_slot_chk
    slot_data_a: assert property (rd_en_o[g] |=> s_write($past(src[g])))
      else $error("loaded value does not match the enabled source");
  end
  sp_top_bit_a: assert property (rd_en_o[ALCR_IDX_SP] |=> !acc_data_o[3])
    else $error("stack pointer load left accumulator bit three set");

  // ****************************************************************
  // Reset
  // ****************************************************************
  // Reset is checked with the default disable switched off.
  reset_clear_a: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> !acc_we_o && (acc_data_o == ALCR_ACC_RST))
    else $error("accumulator not cleared by reset");

endmodule

// file: design/alcr_decode.sv
// Opcode decoder giving one select line per load instruction.
`timescale 1ns/10ps
module alcr_decode import alcr_pkg::*; #(
  parameter logic [9:0] ADC_C_OPCODE = ALCR_OP_LOAD_ADC_CTRL_C
) (
  // Instruction.
  input wire logic valid_i,
  input wire logic [9:0] opcode_i,
  // Selects.
  output logic [ALCR_NOPS-1:0] sel_o
);

  // ****************************************************************
  // Per-slot compare
  // ****************************************************************
  for (genvar g = 0; g < ALCR_NOPS; g++) begin : g_cmp
    localparam logic [9:0] CODE = (g == ALCR_IDX_ADC_C) ? ADC_C_OPCODE : ALCR_OP_TABLE[g];
    assign sel_o[g] = valid_i && (opcode_i == CODE);
  end

endmodule

// file: design/alcr_pkg.sv
// Constants shared by the accumulator load-from-control-register decoder.
package alcr_pkg;

  // ****************************************************************
  // Group size and source slots
  // ****************************************************************
  localparam int ALCR_NOPS = 8;
  localparam int ALCR_IDX_ADC_B = 0;
  localparam int ALCR_IDX_ADC_C = 1;
  localparam int ALCR_IDX_SP = 2;
  localparam int ALCR_IDX_IRQ_A = 3;
  localparam int ALCR_IDX_IRQ_B = 4;
  localparam int ALCR_IDX_TMR_A = 5;
  localparam int ALCR_IDX_TMR_B = 6;
  localparam int ALCR_IDX_TMR_C = 7;

  // ****************************************************************
  // Ten-bit program word codes
  // ****************************************************************
  localparam logic [9:0] ALCR_OP_LOAD_ADC_CTRL_B = 10'h245;
  localparam logic [9:0] ALCR_OP_LOAD_ADC_CTRL_C = 10'h246;
  localparam logic [9:0] ALCR_OP_LOAD_STACK_POINTER = 10'h050;
  localparam logic [9:0] ALCR_OP_LOAD_IRQ_CTRL_A = 10'h054;
  localparam logic [9:0] ALCR_OP_LOAD_IRQ_CTRL_B = 10'h055;
  localparam logic [9:0] ALCR_OP_LOAD_TIMER_CTRL_A = 10'h24b;
  localparam logic [9:0] ALCR_OP_LOAD_TIMER_CTRL_B = 10'h24c;
  localparam logic [9:0] ALCR_OP_LOAD_TIMER_CTRL_C = 10'h24d;

  // Table ordered by slot index, slot 0 in the low bits.
  localparam logic [ALCR_NOPS-1:0][9:0] ALCR_OP_TABLE = {
    ALCR_OP_LOAD_TIMER_CTRL_C, ALCR_OP_LOAD_TIMER_CTRL_B, ALCR_OP_LOAD_TIMER_CTRL_A,
    ALCR_OP_LOAD_IRQ_CTRL_B, ALCR_OP_LOAD_IRQ_CTRL_A, ALCR_OP_LOAD_STACK_POINTER,
    ALCR_OP_LOAD_ADC_CTRL_C, ALCR_OP_LOAD_ADC_CTRL_B};

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [3:0] ALCR_ACC_RST = 4'h0;

endpackage

// file: test/alcr_tb.sv
// Self-checking bench for the accumulator load decoder.
`timescale 1ns/10ps
module alcr_tb import alcr_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic instr_valid_i = 1'b0;
  logic [9:0] opcode_i = 10'h000;
  logic [3:0] adc_b = 4'h9, adc_c = 4'h6, irq_a = 4'ha, irq_b = 4'h3, tmr_a = 4'hc, tmr_b = 4'he, tmr_c = 4'h1;
  logic [2:0] sp = 3'h5;
  logic [ALCR_NOPS-1:0] rd_en;
  logic hit, acc_we, carry_we, skip;
  logic [3:0] acc_data;
  int fail_count = 0;
  int checks_done = 0;

  alcr_core uut (.clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i), .opcode_i(opcode_i),
    .adc_ctrl_b_i(adc_b), .adc_ctrl_c_i(adc_c), .stack_pointer_i(sp), .irq_ctrl_a_i(irq_a),
    .irq_ctrl_b_i(irq_b), .timer_ctrl_a_i(tmr_a), .timer_ctrl_b_i(tmr_b), .timer_ctrl_c_i(tmr_c),
    .rd_en_o(rd_en), .hit_o(hit), .acc_we_o(acc_we), .acc_data_o(acc_data),
    .carry_we_o(carry_we), .skip_o(skip));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // ****************************************************************
  // Shared drivers and comparisons
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] expect_v);
    checks_done++;
    if (seen !== expect_v) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, expect_v);
    end
  endtask

  task automatic issue(input logic v, input logic [9:0] op);
    @(posedge clk_i);
    instr_valid_i <= v;
    opcode_i <= op;
    @(negedge clk_i);
    check({7'h00, carry_we | skip}, 8'h00);
  endtask

  task automatic acc_is(input logic we, input logic [3:0] d);
    check({3'h0, acc_we, acc_data}, {3'h0, we, d});
  endtask

  task automatic sel_is(input logic [7:0] e);
    check(rd_en, e);
    check({7'h00, hit}, {7'h00, |e});
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    @(negedge clk_i);
    acc_is(1'b0, ALCR_ACC_RST);
    issue(1'b1, ALCR_OP_LOAD_ADC_CTRL_B);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(negedge clk_i);
    acc_is(1'b1, adc_b);
    @(posedge clk_i);
    rst_i <= 1'b0;
    instr_valid_i <= 1'b0;
    @(negedge clk_i);
    acc_is(1'b0, ALCR_ACC_RST);
    $display("reset test done");
  endtask

  // Every code back to back, one load per cycle.
  task automatic t_all();
    logic [3:0] exp_v [ALCR_NOPS];
    exp_v = '{adc_b, adc_c, {1'b0, sp}, irq_a, irq_b, tmr_a, tmr_b, tmr_c};
    for (int i = 0; i <= ALCR_NOPS; i++) begin
      issue(i < ALCR_NOPS, ALCR_OP_TABLE[i % ALCR_NOPS]);
      sel_is((i < ALCR_NOPS) ? (8'h01 << i) : 8'h00);
      if (i > 0) acc_is(1'b1, exp_v[i-1]);
    end
    @(negedge clk_i);
    acc_is(1'b0, tmr_c);
    $display("all codes test done");
  endtask

  task automatic t_refuse();
    issue(1'b1, 10'h244);
    sel_is(8'h00);
    issue(1'b0, ALCR_OP_LOAD_IRQ_CTRL_A);
    sel_is(8'h00);
    acc_is(1'b0, tmr_c);
    @(negedge clk_i);
    acc_is(1'b0, tmr_c);
    $display("refusal test done");
  endtask

  task automatic t_sp();
    @(posedge clk_i);
    sp <= 3'h7;
    issue(1'b1, ALCR_OP_LOAD_TIMER_CTRL_A);
    issue(1'b1, ALCR_OP_LOAD_STACK_POINTER);
    acc_is(1'b1, tmr_a);
    issue(1'b0, ALCR_OP_LOAD_STACK_POINTER);
    acc_is(1'b1, 4'h7);
    $display("stack pointer test done");
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_all();
    t_refuse();
    t_sp();
    end_of_test();
  end
endmodule
